// ==== clk_sync_pkg.sv ====
// Package: register map, field layout and codes for clock and frame-sync select
package clk_sync_pkg;
  localparam int ADDR_W = 20;
  localparam int NUM_CLK_TRANS = 3;
  localparam int NUM_SYNC_TRANS = 6;
  localparam int NUM_PORTS = 9;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CLK_SRC_A = 20'h4_6140;
  localparam logic [ADDR_W-1:0] OFS_CLK_SRC_B = 20'h4_6144;
  localparam logic [ADDR_W-1:0] OFS_CLK_SRC_C = 20'h4_6148;
  localparam logic [ADDR_W-1:0] OFS_SYNC_A = 20'h6_0404;
  localparam logic [ADDR_W-1:0] OFS_SYNC_B = 20'h6_1404;
  localparam logic [ADDR_W-1:0] OFS_SYNC_C = 20'h6_2404;
  localparam logic [ADDR_W-1:0] OFS_SYNC_D = 20'h6_3404;
  localparam logic [ADDR_W-1:0] OFS_SYNC_SER0 = 20'h6_B404;
  localparam logic [ADDR_W-1:0] OFS_SYNC_SER1 = 20'h6_BC04;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CLK_SEL_LSB = 28;
  localparam int CLK_SEL_MSB = 31;
  localparam int GEN_EN_BIT = 31;
  localparam int GEN_MODE_LSB = 29;
  localparam int GEN_MODE_MSB = 30;
  localparam int PRI_SEL_LSB = 0;
  localparam int PRI_SEL_MSB = 2;
  localparam logic [3:0] CLK_SEL_RESET = 4'h0;
  localparam logic [2:0] PRI_SEL_RESET = 3'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CLK_NONE = 4'h0;
  localparam logic [3:0] CLK_FIXED_FIRST = 4'h1;
  localparam logic [3:0] CLK_TYPEC_LAST = 4'h9;
  localparam logic [2:0] PRI_TRANS_A = 3'h1;
  localparam logic [2:0] PRI_TRANS_C = 3'h3;

  typedef enum logic [1:0] {
    ROLE_LOCAL_SECONDARY = 2'b00,
    ROLE_REMOTE_SECONDARY = 2'b01,
    ROLE_PRIMARY = 2'b10,
    ROLE_RESERVED = 2'b11
  } role_e;
endpackage : clk_sync_pkg

// ==== sync_role_unit.sv ====
// Per-transcoder frame-sync role decode and sync routing
module sync_role_unit
  import clk_sync_pkg::*;
#(
  parameter logic [2:0] SELF_CODE = 3'h0
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic gen_enable,
  input wire role_e gen_mode,
  input wire logic [2:0] pri_sel,
  input wire logic [NUM_CLK_TRANS-1:0] peer_frame_start,
  input wire logic own_frame_start,
  input wire logic remote_frame_sync,
  output logic sync_out,
  output logic sync_in,
  output logic locked_role
);
  logic local_pick;
  logic self_pick;
  logic valid_pick;

  always_comb begin
    valid_pick = (pri_sel >= PRI_TRANS_A) && (pri_sel <= PRI_TRANS_C);
    self_pick = (pri_sel == SELF_CODE);
    local_pick = 1'b0;
    if (valid_pick) begin
      local_pick = peer_frame_start[2'(pri_sel - PRI_TRANS_A)]; // see R9
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync_out <= 1'b0;
      sync_in <= 1'b0;
      locked_role <= 1'b0;
    end else if (ce) begin
      sync_out <= 1'b0;
      sync_in <= 1'b0;
      locked_role <= 1'b0;
      if (gen_enable) begin // see R5
        case (gen_mode)
          ROLE_PRIMARY: begin
            sync_out <= own_frame_start; // see R6
            locked_role <= 1'b1;
          end
          ROLE_LOCAL_SECONDARY: begin
            // Self-follow would loop, so it is ignored
            if (valid_pick && !self_pick) begin // see R10
              sync_in <= local_pick; // see R7
              locked_role <= 1'b1;
            end
          end
          ROLE_REMOTE_SECONDARY: begin
            sync_in <= remote_frame_sync; // see R8
            locked_role <= 1'b1;
          end
          default: begin
            locked_role <= 1'b0; // see R8
          end
        endcase
      end
    end
  end
endmodule : sync_role_unit

// ==== transcoder_clock_sync_select.sv ====
// Transcoder port clock routing and frame-sync role registers
// Notes on behaviour
// R1: Each of transcoders A, B and C has a register that routes one port clock.
// R2: Bits 31:28 select the clock, and code 0000b leaves the clock off.
// R3: Codes 0001b-0011b pick fixed ports, 0100b-1001b the six type-C ports.
// R4: Software keeps the selector steady while its transcoder is enabled; the testbench rewrites routed selectors, with no glitch guard.
// R5: The genlock role applies only while bit 31 is set.
// R6: Mode 10b makes the transcoder a primary that drives frame sync out.
// R7: Mode 00b follows a local primary named by the primary selector.
// R8: Mode 01b follows a remote primary; 11b is reserved and unused.
// R9: Primary selector bits 2:0 code 001b, 010b, 011b name A, B, C.
// R10: Software never points a primary selector at its own transcoder; the testbench does, and the role unit ignores such a pick.
module transcoder_clock_sync_select
  import clk_sync_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rack,
  input wire logic [NUM_SYNC_TRANS-1:0] frame_start,
  input wire logic remote_frame_sync,
  output logic [NUM_CLK_TRANS-1:0] trans_clk_on,
  output logic [NUM_CLK_TRANS-1:0][NUM_PORTS-1:0] port_clk_route,
  output logic [NUM_SYNC_TRANS-1:0] frame_sync_drive,
  output logic [NUM_SYNC_TRANS-1:0] frame_sync_follow,
  output logic [NUM_SYNC_TRANS-1:0] genlock_active
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  localparam logic [NUM_CLK_TRANS-1:0][ADDR_W-1:0] CLK_OFS = {
    OFS_CLK_SRC_C, OFS_CLK_SRC_B, OFS_CLK_SRC_A};
  localparam logic [NUM_SYNC_TRANS-1:0][ADDR_W-1:0] SYNC_OFS = {
    OFS_SYNC_SER1, OFS_SYNC_SER0, OFS_SYNC_D,
    OFS_SYNC_C, OFS_SYNC_B, OFS_SYNC_A};

  logic [NUM_CLK_TRANS-1:0][3:0] clk_sel;
  logic [NUM_SYNC_TRANS-1:0] gen_en;
  role_e gen_mode [NUM_SYNC_TRANS];
  logic [NUM_SYNC_TRANS-1:0][2:0] pri_sel;
  logic [31:0] next_rdata;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_CLK_TRANS; i++) begin
        clk_sel[i] <= CLK_SEL_RESET;
      end
    end else if (ce && reg_wr) begin
      for (int i = 0; i < NUM_CLK_TRANS; i++) begin
        if (reg_addr == CLK_OFS[i]) begin
          clk_sel[i] <= reg_wdata[CLK_SEL_MSB:CLK_SEL_LSB]; // see R1
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_SYNC_TRANS; i++) begin
        gen_en[i] <= 1'b0;
        gen_mode[i] <= ROLE_LOCAL_SECONDARY;
        pri_sel[i] <= PRI_SEL_RESET;
      end
    end else if (ce && reg_wr) begin
      for (int i = 0; i < NUM_SYNC_TRANS; i++) begin
        if (reg_addr == SYNC_OFS[i]) begin
          gen_en[i] <= reg_wdata[GEN_EN_BIT];
          gen_mode[i] <= role_e'(reg_wdata[GEN_MODE_MSB:GEN_MODE_LSB]);
          pri_sel[i] <= reg_wdata[PRI_SEL_MSB:PRI_SEL_LSB];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reserved bits and unmapped offsets read zero
  always_comb begin
    next_rdata = READ_ZERO;
    for (int i = 0; i < NUM_CLK_TRANS; i++) begin
      if (reg_addr == CLK_OFS[i]) begin
        next_rdata[CLK_SEL_MSB:CLK_SEL_LSB] = clk_sel[i];
      end
    end
    for (int i = 0; i < NUM_SYNC_TRANS; i++) begin
      if (reg_addr == SYNC_OFS[i]) begin
        next_rdata[GEN_EN_BIT] = gen_en[i];
        next_rdata[GEN_MODE_MSB:GEN_MODE_LSB] = gen_mode[i];
        next_rdata[PRI_SEL_MSB:PRI_SEL_LSB] = pri_sel[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= READ_ZERO;
      reg_rack <= 1'b0;
    end else if (ce) begin
      reg_rack <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock routing
  // ----------------------------------------------------------------
  // Selector is trusted to stay put while running; no glitch guard
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trans_clk_on <= '0;
      port_clk_route <= '0;
    end else if (ce) begin
      for (int i = 0; i < NUM_CLK_TRANS; i++) begin
        port_clk_route[i] <= '0;
        trans_clk_on[i] <= 1'b0; // see R2
        if (clk_sel[i] >= CLK_FIXED_FIRST &&
            clk_sel[i] <= CLK_TYPEC_LAST) begin // see R2
          // Codes above the type-C range are left as no source
          port_clk_route[i][4'(clk_sel[i] - CLK_FIXED_FIRST)] <= 1'b1; // see R3
          trans_clk_on[i] <= 1'b1; // see R2
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame-sync roles
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_SYNC_TRANS; g++) begin : g_sync
    // Transcoder D and the serial transcoders have no code of their own, so self match is none
    localparam logic [2:0] SELF = (g < NUM_CLK_TRANS) ?
      3'(g + 1) : 3'h0;
    sync_role_unit #(
      .SELF_CODE(SELF)
    ) u_role (
      .core_clk(core_clk),
      .srst(srst),
      .ce(ce),
      .gen_enable(gen_en[g]),
      .gen_mode(gen_mode[g]),
      .pri_sel(pri_sel[g]),
      .peer_frame_start(frame_start[NUM_CLK_TRANS-1:0]),
      .own_frame_start(frame_start[g]),
      .remote_frame_sync(remote_frame_sync),
      .sync_out(frame_sync_drive[g]),
      .sync_in(frame_sync_follow[g]),
      .locked_role(genlock_active[g])
    );
  end
endmodule : transcoder_clock_sync_select

// ==== tcs_props.sv ====
// Checker: port properties of the clock and frame-sync select block
module tcs_props
  import clk_sync_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic reg_rd,
  input wire logic reg_rack,
  input wire logic [NUM_SYNC_TRANS-1:0] frame_start,
  input wire logic remote_frame_sync,
  input wire logic [NUM_CLK_TRANS-1:0] trans_clk_on,
  input wire logic [NUM_CLK_TRANS-1:0][NUM_PORTS-1:0] port_clk_route,
  input wire logic [NUM_SYNC_TRANS-1:0] frame_sync_drive,
  input wire logic [NUM_SYNC_TRANS-1:0] frame_sync_follow,
  input wire logic [NUM_SYNC_TRANS-1:0] genlock_active
);
  default clocking @(posedge core_clk); endclocking
  // Frozen cycles give no new answers, so they are skipped
  default disable iff (srst || !ce);
  chk_rack_after_read: assert property (reg_rd |=> reg_rack)
    else $error("read not answered");
  chk_rack_has_cause: assert property (reg_rack |-> $past(reg_rd))
    else $error("answer without read");
  chk_clk_on_route: assert property (
    trans_clk_on == {|port_clk_route[2], |port_clk_route[1],
    |port_clk_route[0]})
    else $error("clock on disagrees with route");
  chk_route_one_hot: assert property (
    $onehot0(port_clk_route[0]) && $onehot0(port_clk_route[1]) &&
    $onehot0(port_clk_route[2]))
    else $error("route not one-hot");
  chk_drive_cause: assert property (
    (frame_sync_drive & ~$past(frame_start)) == '0)
    else $error("drive without frame start");
  chk_role_gated: assert property (
    ((frame_sync_drive | frame_sync_follow) & ~genlock_active) == '0)
    else $error("sync while role inactive");
  chk_follow_src_a: assert property (
    frame_sync_follow[0] |-> $past(remote_frame_sync) ||
    $past(frame_start[1]) || $past(frame_start[2]))
    else $error("transcoder A followed a bad source");
  chk_follow_src_b: assert property (
    frame_sync_follow[1] |-> $past(remote_frame_sync) ||
    $past(frame_start[0]) || $past(frame_start[2]))
    else $error("transcoder B followed a bad source");
  cover property (frame_sync_drive[0]);
  cover property (frame_sync_follow[1]);
  cover property (reg_rack);
endmodule : tcs_props

bind transcoder_clock_sync_select tcs_props u_props (.core_clk(core_clk),
  .srst(srst), .ce(ce), .reg_rd(reg_rd), .reg_rack(reg_rack),
  .frame_start(frame_start), .remote_frame_sync(remote_frame_sync),
  .trans_clk_on(trans_clk_on), .port_clk_route(port_clk_route),
  .frame_sync_drive(frame_sync_drive),
  .frame_sync_follow(frame_sync_follow),
  .genlock_active(genlock_active));

// ==== frame_src_model.sv ====
// Partner model: peer transcoder frame starts and remote frame sync
module frame_src_model
  import clk_sync_pkg::*;
#(
  parameter int PERIOD = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  output logic [NUM_SYNC_TRANS-1:0] frame_start = '0,
  output logic remote_frame_sync = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Staggered phases keep every source's pulse distinguishable
  always @(negedge core_clk) begin
    cnt <= (srst || cnt == PERIOD - 1) ? 0 : cnt + 1;
    frame_start <= srst ? '0 : NUM_SYNC_TRANS'(1 << cnt);
    remote_frame_sync <= !srst && cnt == 6;
  end
endmodule : frame_src_model

// ==== tb_top.sv ====
// Testbench: register access, clock routing and frame-sync roles
module tb_top
  import clk_sync_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, srst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic reg_rack, remote_frame_sync;
  logic [NUM_SYNC_TRANS-1:0] frame_start, frame_sync_drive;
  logic [NUM_SYNC_TRANS-1:0] frame_sync_follow, genlock_active;
  logic [NUM_CLK_TRANS-1:0] trans_clk_on;
  logic [NUM_CLK_TRANS-1:0][NUM_PORTS-1:0] port_clk_route;
  int bad_count = 0, n_checks = 0;
  logic [ADDR_W-1:0] regs [9] = '{OFS_CLK_SRC_A, OFS_CLK_SRC_B,
    OFS_CLK_SRC_C, OFS_SYNC_A, OFS_SYNC_B, OFS_SYNC_C, OFS_SYNC_D,
    OFS_SYNC_SER0, OFS_SYNC_SER1};
  transcoder_clock_sync_select DUT (.core_clk, .srst, .ce, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rack, .frame_start,
    .remote_frame_sync, .trans_clk_on, .port_clk_route, .frame_sync_drive,
    .frame_sync_follow, .genlock_active);
  frame_src_model u_src (.core_clk, .srst, .frame_start, .remote_frame_sync);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge core_clk);
    reg_wr = 0;
    repeat (2) @(negedge core_clk);
  endtask : wr
  task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] exp);
    int n;
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge core_clk);
    reg_rd = 0;
    for (n = 0; n < 4 && reg_rack !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 4) begin
      bad_count++;
      end_sim();
    end
    check("rdata", reg_rdata, exp);
  endtask : rd
  task automatic t_regs();
    for (int i = 0; i < 9; i++)
      rd(regs[i], 32'h0000_0000);
    wr(20'h4_6150, 32'hFFFF_FFFF);
    rd(20'h4_6150, 32'h0000_0000);
    wr(OFS_CLK_SRC_B, 32'hFFFF_FFFF);
    rd(OFS_CLK_SRC_B, 32'hF000_0000);
    wr(OFS_SYNC_D, 32'hFFFF_FFFF);
    rd(OFS_SYNC_D, 32'hE000_0007);
    wr(OFS_SYNC_D, 32'h0000_0000);
  endtask : t_regs
  task automatic t_clk();
    logic [NUM_PORTS-1:0] exp;
    for (int c = 0; c < 16; c++) begin
      exp = (c >= 1 && c <= 9) ? NUM_PORTS'(1) << (c - 1) : '0;
      // Selector rewritten even while its transcoder clock is still routed
      wr(OFS_CLK_SRC_A + 20'(4 * (c % 3)), {4'(c), 28'h000_0000});
      check("route", port_clk_route[c % 3], exp);
      check("clk_on", trans_clk_on[c % 3], |exp);
    end
  endtask : t_clk
  task automatic t_freeze();
    // Write strobed while frozen must not land
    ce = 0;
    wr(OFS_CLK_SRC_A, 32'h1000_0000);
    ce = 1;
    repeat (2) @(negedge core_clk);
    check("frozen_route", port_clk_route[0], 32'h0000_0000);
    check("frozen_clk_on", trans_clk_on[0], 32'h0000_0000);
    wr(OFS_CLK_SRC_A, 32'h1000_0000);
    check("route", port_clk_route[0], 32'h0000_0001);
    wr(OFS_CLK_SRC_A, 32'h0000_0000);
  endtask : t_freeze
  task automatic sync_case(logic [ADDR_W-1:0] a, logic [31:0] v, int i,
      int ds, int fs, logic act);
    logic [7:0] src;
    wr(a, v);
    check("active", genlock_active[i], act);
    repeat (16) begin
      // Sources taken at the edge where the design samples them
      @(posedge core_clk);
      src = {1'b0, remote_frame_sync, frame_start};
      @(negedge core_clk);
      check("drive", frame_sync_drive[i], src[ds]);
      check("follow", frame_sync_follow[i], src[fs]);
    end
    wr(a, 32'h0000_0000);
  endtask : sync_case
  initial begin
    repeat (12) @(negedge core_clk);
    srst = 0;
    t_regs();
    t_clk();
    t_freeze();
    sync_case(OFS_SYNC_A, 32'hC000_0000, 0, 0, 7, 1);
    sync_case(OFS_SYNC_A, 32'h4000_0000, 0, 7, 7, 0);
    sync_case(OFS_SYNC_B, 32'h8000_0001, 1, 7, 0, 1);
    sync_case(OFS_SYNC_A, 32'h8000_0002, 0, 7, 1, 1);
    sync_case(OFS_SYNC_SER1, 32'h8000_0003, 5, 7, 2, 1);
    sync_case(OFS_SYNC_D, 32'hA000_0000, 3, 7, 6, 1);
    sync_case(OFS_SYNC_A, 32'hE000_0000, 0, 7, 7, 0);
    sync_case(OFS_SYNC_A, 32'h8000_0001, 0, 7, 7, 0);
    sync_case(OFS_SYNC_B, 32'h8000_0000, 1, 7, 7, 0);
    end_sim();
  end
endmodule : tb_top
